// ==== rtl/emi_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "emi_map.svh"
// Behaviour
// - Eight-bit pointer accesses take their high address byte from the page register
// - Port group select clear uses lower port group, set uses upper group
// - Mux mode bit clear shares low address with data, set separates them
// - Map mode 00 sends everything on-chip, wrapping at 8 k
// - Mode 01 splits at 8 k; off-chip 8-bit access leaves upper pins undriven
// - Mode 10 splits at 8 k; 8-bit off-chip access drives page and index
// - Split modes decide by the effective 16-bit address; 16-bit pointer accesses drive all sixteen bits
// - Mode 11 is all off-chip; 8-bit access ignores page, upper pins undriven
// - Latch strobe width field sets high and low times of 1 to 4 cycles
// - Mux mode: latch strobe high with low address, then data with strobe
// - Setup, hold, strobe and latch widths are whole clock periods
// - Off-chip access lasts programmed times plus four cycles, five minimum
// - Mux mode adds latch phases, at least two cycles, seven minimum
// - Setup and hold settings reset to their largest values
// - Top two configuration bits read zero and ignore writes
// - Port pins are claimed only while an off-chip access runs
// - Drivers of input pins, such as data on reads, are disabled
module emi_top
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CORE_VALID,
  input wire emi_pkg::emi_req_t CORE_REQ,
  output logic CORE_READY,
  output logic CORE_DONE,
  output logic [7:0] CORE_RDATA,
  input wire logic [31:0] PORT_LO_IN,
  output logic [31:0] PORT_LO_OUT,
  output logic [31:0] PORT_LO_OE,
  input wire logic [31:0] PORT_HI_IN,
  output logic [31:0] PORT_HI_OUT,
  output logic [31:0] PORT_HI_OE
);
  import emi_pkg::*;

  logic [5:0] cfg_reg;
  logic [7:0] page_reg;
  logic [7:0] tmg_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  emi_state_t st_reg;
  emi_state_t st_next;
  logic [3:0] cnt_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic write_reg;
  logic drive_hi_reg;
  logic nmux_reg;
  logic prt_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;
  logic [7:0] ram_mem [0:`EMI_RAM_WORDS-1];
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic [31:0] grp_out_reg [0:1];
  logic [31:0] grp_oe_reg [0:1];
  logic [7:0] eff_hi;
  logic [15:0] eff_addr;
  logic offchip;
  logic accept;
  logic [9:0] reg_idx;
  logic apb_wr;
  logic [3:0] phase_len;

  // Decoding used for the error response of both reads and writes
  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == `EMI_CFG_IDX) || (idx == `EMI_PAGE_IDX) ||
      (idx == `EMI_TMG_IDX) || (idx == `EMI_STAT_IDX);
  endfunction

  assign reg_idx = PADDR[11:2];
  assign apb_wr = PSEL && PENABLE && pready_reg && PWRITE;

  // One wait state on every transfer keeps read data registered
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= PSEL && PENABLE && !pready_reg;
      pslverr_reg <= PSEL && PENABLE && !pready_reg && !idx_mapped(reg_idx);
      prdata_reg <= 32'h0000_0000;
      if (PSEL && PENABLE && !pready_reg && !PWRITE)
      begin
        case (reg_idx)
          `EMI_CFG_IDX: prdata_reg <= {24'h00_0000, 2'b00, cfg_reg};
          `EMI_PAGE_IDX: prdata_reg <= {24'h00_0000, page_reg};
          `EMI_TMG_IDX: prdata_reg <= {24'h00_0000, tmg_reg};
          `EMI_STAT_IDX: prdata_reg <= {23'h00_0000, st_reg != EMI_IDLE,
            rdata_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_reg <= 6'(`EMI_CFG_RST);
      page_reg <= `EMI_PAGE_RST;
      tmg_reg <= `EMI_TMG_RST;
    end
    else if (apb_wr)
    begin
      case (reg_idx)
        `EMI_CFG_IDX: cfg_reg <= PWDATA[5:0] & 6'(`EMI_CFG_WMASK);
        `EMI_PAGE_IDX: page_reg <= PWDATA[7:0];
        `EMI_TMG_IDX: tmg_reg <= PWDATA[7:0];
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // Effective address and on-chip/off-chip decision
  assign eff_hi = CORE_REQ.ptr8 ? page_reg : CORE_REQ.pointer[15:8];
  assign eff_addr = {eff_hi, CORE_REQ.ptr8 ? CORE_REQ.index :
    CORE_REQ.pointer[7:0]};
  always_comb
  begin
    case (cfg_reg[`EMI_CFG_MODE])
      `EMI_MODE_INT: offchip = 1'b0;
      `EMI_MODE_EXT: offchip = 1'b1;
      default: offchip = eff_addr >= `EMI_ONCHIP_TOP;
    endcase
  end
  assign accept = CORE_VALID && (st_reg == EMI_IDLE);

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      EMI_IDLE:
        if (accept)
          st_next = offchip ? EMI_START : EMI_RAM;
      EMI_RAM: st_next = EMI_IDLE;
      EMI_START:
        if (nmux_reg)
          st_next = (tmg_reg[`EMI_TMG_SETUP] == 2'b00) ? EMI_STRB : EMI_SETUP;
        else
          st_next = EMI_ALEH;
      EMI_ALEH:
        if (cnt_reg[1:0] == cfg_reg[`EMI_CFG_ALE])
          st_next = EMI_ALEL;
      EMI_ALEL:
        if (cnt_reg[1:0] == cfg_reg[`EMI_CFG_ALE])
          st_next = (tmg_reg[`EMI_TMG_SETUP] == 2'b00) ? EMI_STRB : EMI_SETUP;
      EMI_SETUP:
        if (cnt_reg[1:0] == tmg_reg[`EMI_TMG_SETUP] - 2'b01)
          st_next = EMI_STRB;
      EMI_STRB:
        if (cnt_reg == tmg_reg[`EMI_TMG_STRB])
          st_next = (tmg_reg[`EMI_TMG_HOLD] == 2'b00) ? EMI_END : EMI_HOLD;
      EMI_HOLD:
        if (cnt_reg[1:0] == tmg_reg[`EMI_TMG_HOLD] - 2'b01)
          st_next = EMI_END;
      EMI_END:
        if (cnt_reg[0])
          st_next = EMI_IDLE;
      default: st_next = EMI_IDLE;
    endcase
  end

  // Overhead is the start cycle, two end cycles and the done cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_reg <= EMI_IDLE;
      cnt_reg <= 4'h0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= (st_next != st_reg) ? 4'h0 : cnt_reg + 4'h1;
    end
  end

  // Request, mux bit and port group are captured once; latch width and timing fields are read live
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      write_reg <= 1'b0;
      drive_hi_reg <= 1'b0;
      nmux_reg <= 1'b0;
      prt_reg <= 1'b0;
    end
    else if (accept)
    begin
      addr_reg <= eff_addr;
      wdata_reg <= CORE_REQ.wdata;
      write_reg <= CORE_REQ.write;
      drive_hi_reg <= !CORE_REQ.ptr8 ||
        (cfg_reg[`EMI_CFG_MODE] == `EMI_MODE_BANK);
      nmux_reg <= cfg_reg[`EMI_CFG_NMUX];
      prt_reg <= cfg_reg[`EMI_CFG_PRT];
    end
  end

  // On-chip RAM; the index wraps modulo the 8 k space
  always_ff @(posedge REF_CLK)
  begin
    if (st_reg == EMI_RAM && write_reg)
      ram_mem[addr_reg[12:0]] <= wdata_reg;
  end

  // Both groups are synchronised; the group is picked after the second flop
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      din_s1_reg <= 16'h0000;
      din_s2_reg <= 16'h0000;
    end
    else
    begin
      din_s1_reg <= {PORT_HI_IN[`EMI_PIN_DAT], PORT_LO_IN[`EMI_PIN_DAT]};
      din_s2_reg <= din_s1_reg;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (st_reg == EMI_RAM) ||
        (st_reg == EMI_END && st_next == EMI_IDLE);
      if (st_reg == EMI_RAM && !write_reg)
        rdata_reg <= ram_mem[addr_reg[12:0]];
      else if (st_reg == EMI_STRB && st_next != EMI_STRB && !write_reg)
        rdata_reg <= prt_reg ? din_s2_reg[15:8] : din_s2_reg[7:0];
    end
  end

  // Pin image of the active access; idle pins are released
  always_comb
  begin
    pin_out = `EMI_PARK;
    pin_oe = 32'h0000_0000;
    if (st_reg != EMI_IDLE && st_reg != EMI_RAM)
    begin
      pin_out[`EMI_PIN_ALE] = (st_reg == EMI_ALEH);
      pin_out[`EMI_PIN_RD] = !(st_reg == EMI_STRB && !write_reg);
      pin_out[`EMI_PIN_WR] = !(st_reg == EMI_STRB && write_reg);
      pin_out[`EMI_PIN_AHI] = addr_reg[15:8];
      pin_out[`EMI_PIN_ALO] = addr_reg[7:0];
      pin_oe[`EMI_PIN_RD] = 1'b1;
      pin_oe[`EMI_PIN_WR] = 1'b1;
      pin_oe[`EMI_PIN_ALE] = !nmux_reg;
      pin_oe[`EMI_PIN_AHI] = {8{drive_hi_reg}};
      pin_oe[`EMI_PIN_ALO] = {8{nmux_reg}};
      if (!nmux_reg && (st_reg == EMI_START || st_reg == EMI_ALEH))
      begin
        pin_out[`EMI_PIN_DAT] = addr_reg[7:0];
        pin_oe[`EMI_PIN_DAT] = 8'hFF;
      end
      else
      begin
        pin_out[`EMI_PIN_DAT] = wdata_reg;
        pin_oe[`EMI_PIN_DAT] = {8{write_reg}};
      end
    end
  end

  // Only the selected group follows the access, the other stays released
  generate
    for (genvar g = 0; g < 2; g++)
    begin : grp
      always_ff @(posedge REF_CLK or posedge RST)
      begin
        if (RST)
        begin
          grp_out_reg[g] <= `EMI_PARK;
          grp_oe_reg[g] <= 32'h0000_0000;
        end
        else
        begin
          grp_out_reg[g] <= (prt_reg == 1'(g)) ? pin_out : `EMI_PARK;
          grp_oe_reg[g] <= (prt_reg == 1'(g)) ? pin_oe : 32'h0000_0000;
        end
      end
    end
  endgenerate

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign CORE_READY = (st_reg == EMI_IDLE);
  assign CORE_DONE = done_reg;
  assign CORE_RDATA = rdata_reg;
  assign PORT_LO_OUT = grp_out_reg[0];
  assign PORT_LO_OE = grp_oe_reg[0];
  assign PORT_HI_OUT = grp_out_reg[1];
  assign PORT_HI_OE = grp_oe_reg[1];

  // Helper: cycles spent so far in the current state
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      phase_len <= 4'h1;
    else
      phase_len <= (st_next != st_reg) ? 4'h1 : phase_len + 4'h1;
  end

  logic [5:0] acc_len;
  logic [5:0] acc_want;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      acc_len <= 6'h00;
    else if (st_reg == EMI_IDLE)
      acc_len <= 6'h00;
    else
      acc_len <= acc_len + 6'h01;
  end
  assign acc_want = `EMI_OVERHEAD + 6'(tmg_reg[`EMI_TMG_SETUP]) +
    6'(tmg_reg[`EMI_TMG_HOLD]) + 6'(tmg_reg[`EMI_TMG_STRB]) + 6'h01 +
    (nmux_reg ? 6'h00 : 6'({cfg_reg[`EMI_CFG_ALE], 1'b0}) + 6'h02);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  page_addr_a: assert property (accept && CORE_REQ.ptr8 |=>
    addr_reg[15:8] == $past(page_reg)) else $error("page byte not used");
  port_group_a: assert property (st_reg == EMI_STRB && prt_reg |=>
    PORT_LO_OE == 32'h0000_0000 && PORT_HI_OE[`EMI_PIN_RD])
    else $error("wrong port group");
  internal_only_a: assert property (accept &&
    cfg_reg[`EMI_CFG_MODE] == `EMI_MODE_INT |=> st_reg == EMI_RAM)
    else $error("mode 00 went off-chip");
  hi_undriven_a: assert property (st_reg == EMI_STRB && !drive_hi_reg |=>
    (PORT_LO_OE[`EMI_PIN_AHI] | PORT_HI_OE[`EMI_PIN_AHI]) == 8'h00)
    else $error("upper address driven");
  ale_width_a: assert property ($past(st_reg) == EMI_ALEH &&
    st_reg == EMI_ALEL |-> $past(phase_len) ==
    {2'b00, cfg_reg[`EMI_CFG_ALE]} + 4'h1) else $error("latch width");
  strobe_width_a: assert property ($past(st_reg) == EMI_STRB &&
    st_reg != EMI_STRB |-> $past(phase_len) == tmg_reg[`EMI_TMG_STRB] + 4'h1)
    else $error("strobe width");
  access_len_a: assert property (st_reg == EMI_END &&
    st_next == EMI_IDLE |-> acc_len + 6'h02 == acc_want)
    else $error("access length");
  mux_min_a: assert property (accept && offchip &&
    !cfg_reg[`EMI_CFG_NMUX] |-> ##1 (st_reg != EMI_IDLE)[*6])
    else $error("mux access too short");
  read_oe_a: assert property (st_reg == EMI_STRB && !write_reg |=>
    (PORT_LO_OE[`EMI_PIN_DAT] | PORT_HI_OE[`EMI_PIN_DAT]) == 8'h00)
    else $error("data driven on read");
  idle_free_a: assert property (st_reg == EMI_IDLE &&
    $past(st_reg) == EMI_IDLE |=> PORT_LO_OE == 32'h0000_0000 &&
    PORT_HI_OE == 32'h0000_0000) else $error("pins held while idle");
  cfg_top_a: assert property (PREADY && PRDATA[31:6] != 26'h000_0000 |->
    $past(reg_idx) != `EMI_CFG_IDX) else $error("top config bits set");

  mux_write_c: cover property (st_reg == EMI_ALEL && write_reg);
  nmux_read_c: cover property (st_reg == EMI_STRB && !write_reg && nmux_reg);
  ram_c: cover property (st_reg == EMI_RAM);
endmodule
`default_nettype wire

// ==== rtl/emi_map.svh ====
`ifndef EMI_MAP_SVH
`define EMI_MAP_SVH
// Register indices; byte address is four times the index
`define EMI_CFG_IDX 10'h0A3
`define EMI_PAGE_IDX 10'h0A4
`define EMI_TMG_IDX 10'h0A5
`define EMI_STAT_IDX 10'h0A6
`define EMI_CFG_RST 8'h03
`define EMI_PAGE_RST 8'h00
`define EMI_TMG_RST 8'hFF
// Configuration fields
`define EMI_CFG_PRT 5
`define EMI_CFG_NMUX 4
`define EMI_CFG_MODE 3:2
`define EMI_CFG_ALE 1:0
`define EMI_CFG_WMASK 8'h3F
// Timing fields
`define EMI_TMG_SETUP 7:6
`define EMI_TMG_STRB 5:2
`define EMI_TMG_HOLD 1:0
// Memory map
`define EMI_MODE_INT 2'h0
`define EMI_MODE_SPLIT 2'h1
`define EMI_MODE_BANK 2'h2
`define EMI_MODE_EXT 2'h3
`define EMI_RAM_WORDS 8192
`define EMI_ONCHIP_TOP 16'h2000
// Port group layout
`define EMI_PIN_WR 7
`define EMI_PIN_RD 6
`define EMI_PIN_ALE 5
`define EMI_PIN_ALO 15:8
`define EMI_PIN_AHI 23:16
`define EMI_PIN_DAT 31:24
`define EMI_PARK 32'hFFFF_FFFF
// Fixed overhead of an off-chip access
`define EMI_OVERHEAD 6'h04
`endif

// ==== rtl/emi_pkg.sv ====
package emi_pkg;
  typedef enum logic [8:0] {
    EMI_IDLE = 9'h001,
    EMI_RAM = 9'h002,
    EMI_START = 9'h004,
    EMI_ALEH = 9'h008,
    EMI_ALEL = 9'h010,
    EMI_SETUP = 9'h020,
    EMI_STRB = 9'h040,
    EMI_HOLD = 9'h080,
    EMI_END = 9'h100
  } emi_state_t;

  typedef struct packed {
    logic write;
    logic ptr8;
    logic [15:0] pointer;
    logic [7:0] index;
    logic [7:0] wdata;
  } emi_req_t;
endpackage

// ==== bench/emi_sram_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Static RAM on one port group; unclaimed pins float to the parked 1
module emi_sram_model
(
  input wire logic clk,
  input wire logic mux,
  input wire logic [31:0] pout,
  input wire logic [31:0] poe,
  output logic [31:0] pin,
  output logic [15:0] addr_seen,
  output logic bad_oe
);
  logic [7:0] mem [0:65535];
  logic [7:0] alat;
  logic [31:0] lvl;
  logic [15:0] addr;
  assign lvl = (pout & poe) | ~poe;
  assign addr = {lvl[23:16], mux ? alat : lvl[15:8]};
  always_comb
  begin
    pin = lvl;
    if (!lvl[6])
      pin[31:24] = mem[addr];
  end
  initial bad_oe = 1'b0;
  always @(posedge clk)
  begin
    // Latch follows AD while the strobe is high, holds once it falls
    if (lvl[5])
      alat <= lvl[31:24];
    if (!lvl[7])
      mem[addr] <= lvl[31:24];
    if (!lvl[7] || !lvl[6])
      addr_seen <= addr;
    if (!lvl[6] && poe[31:24] != 8'h00)
      bad_oe <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "emi_map.svh"
module testbench;
  import emi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cvalid = 1'b0;
  logic mux = 1'b0;
  emi_req_t creq = '0;
  logic [31:0] prdata, lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe;
  logic pready, pslverr, cready, cdone, lo_bad, hi_bad;
  logic [7:0] crdata;
  logic [15:0] lo_addr, hi_addr;
  logic [7:0] ram [0:8191];
  int miscompares = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  emi_top dut (.REF_CLK(clk), .RST(rst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CORE_VALID(cvalid),
    .CORE_REQ(creq), .CORE_READY(cready), .CORE_DONE(cdone),
    .CORE_RDATA(crdata), .PORT_LO_IN(lo_in), .PORT_LO_OUT(lo_out),
    .PORT_LO_OE(lo_oe), .PORT_HI_IN(hi_in), .PORT_HI_OUT(hi_out),
    .PORT_HI_OE(hi_oe));
  emi_sram_model lo_mem (.clk(clk), .mux(mux), .pout(lo_out), .poe(lo_oe),
    .pin(lo_in), .addr_seen(lo_addr), .bad_oe(lo_bad));
  emi_sram_model hi_mem (.clk(clk), .mux(mux), .pout(hi_out), .poe(hi_oe),
    .pin(hi_in), .addr_seen(hi_addr), .bad_oe(hi_bad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up;
    chk(32'h0000_0000, 32'h0000_0001);
    test_done;
  endtask
  task automatic apb(input logic w, input logic [9:0] idx,
    input logic [7:0] wd, output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
      give_up;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Pins are checked one cycle after done, since their image lags state
  task automatic core(input emi_req_t r, output int cyc,
    output logic [7:0] rd);
    @(posedge clk);
    cvalid <= 1'b1;
    creq <= r;
    @(posedge clk);
    cvalid <= 1'b0;
    // Count includes the edge at which the request is taken
    cyc = 1;
    do
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
    while (cdone !== 1'b1 && cyc < 300);
    if (cyc >= 300)
      give_up;
    rd = crdata;
    @(posedge clk);
    #1;
    chk(lo_oe | hi_oe, 32'h0000_0000);
  endtask
  initial
  begin
    logic [31:0] rd;
    logic err, off;
    emi_req_t r;
    int cyc, ecyc, k, mode, p8, nm, prt;
    logic [7:0] cfg, tmg, got, wd;
    logic [15:0] ea, wa;
    k = $urandom(32'h7644_2c60);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `EMI_CFG_IDX, 8'h00, rd, err);
    chk(rd, 32'h0000_0003);
    apb(1'b0, `EMI_PAGE_IDX, 8'h00, rd, err);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `EMI_TMG_IDX, 8'h00, rd, err);
    chk(rd, 32'h0000_00FF);
    apb(1'b1, `EMI_CFG_IDX, 8'hFF, rd, err);
    apb(1'b0, `EMI_CFG_IDX, 8'h00, rd, err);
    chk(rd, 32'h0000_003F);
    apb(1'b0, 10'h3FF, 8'h00, rd, err);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("registers done");
    for (k = 0; k < 32; k++)
    begin
      mode = k % 4;
      p8 = (k / 4) % 2;
      nm = (k / 8) % 2;
      prt = k / 16;
      cfg = {2'b00, prt[0], nm[0], mode[1:0], 2'($urandom)};
      // Strobe of four or more so read data clears the synchroniser
      tmg = 8'($urandom) | 8'h0C;
      ea = 16'($urandom);
      if (k % 3 == 0)
        ea[15] = 1'b1;
      mux <= ~nm[0];
      apb(1'b1, `EMI_CFG_IDX, cfg, rd, err);
      apb(1'b1, `EMI_TMG_IDX, tmg, rd, err);
      apb(1'b1, `EMI_PAGE_IDX, p8 ? ea[15:8] : 8'($urandom), rd, err);
      off = mode == 3 || (mode != 0 && ea >= 16'h2000);
      wa = (p8 == 1 && mode != 2) ? {8'hFF, ea[7:0]} : ea;
      ecyc = 2;
      if (off)
        ecyc = tmg[7:6] + tmg[1:0] + tmg[5:2] + 5 + (nm ? 0 : 2 * cfg[1:0] + 2);
      r = '{1'b1, p8[0], ea, ea[7:0], 8'($urandom)};
      wd = r.wdata;
      if (!off)
        ram[ea[12:0]] = r.wdata;
      core(r, cyc, got);
      chk(cyc, ecyc);
      if (off)
        chk(prt ? hi_addr : lo_addr, wa);
      // Internal mode reads back through the 8 k alias
      if (mode == 0)
      begin
        ea = ea + 16'h2000;
        apb(1'b1, `EMI_PAGE_IDX, ea[15:8], rd, err);
      end
      r = '{1'b0, p8[0], ea, ea[7:0], 8'h00};
      core(r, cyc, got);
      chk(cyc, ecyc);
      chk(got, off ? wd : ram[ea[12:0]]);
      $display("test %0d done", k);
    end
    chk(lo_bad | hi_bad, 32'h0000_0000);
    test_done;
  end
endmodule
`default_nettype wire
